// File: rtl/lcsq_pkg.sv
// Purpose: Shared constants and types for the light curtain status qualifier
// Assumes: 250 MHz system clock, 1 ms timebase
// Notes: Millisecond figures are 13-bit counts, except the 8-bit demand delay dd_ms
package lcsq_pkg;

  typedef enum logic [1:0] {
    LCSQ_AUTO,
    LCSQ_PUI,
    LCSQ_MAN,
    LCSQ_MAN_OFF
  } lcsq_mode_t;

  typedef enum logic [1:0] {
    LCSQ_BOOT,
    LCSQ_RUN,
    LCSQ_RECONF
  } lcsq_state_t;

  typedef struct packed {
    lcsq_mode_t mode;
    logic multi_scan;
    logic dd_en;
    logic [7:0] dd_ms;
    logic [12:0] latch_ms;
    logic [12:0] on_ms;
    logic [12:0] off_ms;
    logic [7:0] laser_s;
    logic beam_code;
  } lcsq_cfg_t;

  // Timebase
  localparam int unsigned LCSQ_CLK_KHZ = 250000;
  localparam int unsigned LCSQ_TICK_MS = 1;
  localparam int unsigned LCSQ_MS_CYC = LCSQ_TICK_MS * LCSQ_CLK_KHZ;
  localparam int unsigned LCSQ_S_MS = 1000;

  // Restart qualification and reconfiguration hold, in ms
  localparam logic [12:0] LCSQ_RST_HOLD_MS = 13'h0014;
  localparam logic [12:0] LCSQ_RECONF_MS = 13'h0064;

  // Values after reset, and the saturation limit of ms counts
  localparam logic [7:0] LCSQ_DD_MS_RST = 8'h0a;
  localparam logic [12:0] LCSQ_LATCH_MS_RST = 13'h00fa;
  localparam logic [12:0] LCSQ_ON_MS_RST = 13'h01f4;
  localparam logic [12:0] LCSQ_OFF_MS_RST = 13'h00fa;
  localparam logic [7:0] LCSQ_LASER_S_RST = 8'hf0;
  localparam logic [12:0] LCSQ_MS_MAX = 13'h1fff;

  localparam lcsq_cfg_t LCSQ_CFG_RST = '{
    mode: LCSQ_AUTO,
    multi_scan: 1'b0,
    dd_en: 1'b0,
    dd_ms: LCSQ_DD_MS_RST,
    latch_ms: LCSQ_LATCH_MS_RST,
    on_ms: LCSQ_ON_MS_RST,
    off_ms: LCSQ_OFF_MS_RST,
    laser_s: LCSQ_LASER_S_RST,
    beam_code: 1'b0
  };

endpackage : lcsq_pkg

// File: rtl/lcsq_tick.sv
// Purpose: Millisecond and second strobes from the system clock
// Assumes: MS_CYC of at least 2
// Notes: Each strobe is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module lcsq_tick #(
  parameter int unsigned MS_CYC = lcsq_pkg::LCSQ_MS_CYC,
  parameter int unsigned MS_PER_S = lcsq_pkg::LCSQ_S_MS
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  output logic o_ms_tick,
  output logic o_s_tick
);
  localparam int unsigned CW = $clog2(MS_CYC);
  localparam int unsigned SW = $clog2(MS_PER_S);
  logic [CW-1:0] cyc_r;
  logic [SW-1:0] ms_r;

  // Cycle divider
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      cyc_r <= '0;
      o_ms_tick <= 1'b0;
    end
    else
    begin
      o_ms_tick <= (cyc_r == CW'(MS_CYC - 1));
      cyc_r <= (cyc_r == CW'(MS_CYC - 1)) ? '0 : cyc_r + 1'b1;
    end
  end

  // Millisecond divider
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      ms_r <= '0;
      o_s_tick <= 1'b0;
    end
    else
    begin
      o_s_tick <= o_ms_tick && (ms_r == SW'(MS_PER_S - 1));
      if (o_ms_tick)
      begin
        ms_r <= (ms_r == SW'(MS_PER_S - 1)) ? '0 : ms_r + 1'b1;
      end
    end
  end
endmodule : lcsq_tick
`default_nettype wire

// File: rtl/lcsq_top.sv
// Purpose: Qualifies the protective field status of a light curtain
// Assumes: Field, alignment and switch arrive from pins; restart is local
// Notes: One scan per millisecond tick
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Automatic start raises status once beams aligned and field clear.
// - Power-up interlock needs one restart, then behaves automatically.
// - Manual start needs a restart after power-up and every clearing.
// - Manual with off: each further restart toggles status.
// - Restart acts on its falling edge after a minimum high time.
// - Multiple scan confirms an obstruction with one more scan.
// - Demand delay ignores obstructions for 0 to 255 ms, default 10.
// - Status stays low at least the demand latch time.
// - Field must stay clear the chatter-on time before status rises.
// - Three interruptions within chatter-off window lock status low.
// - Receiver laser stays lit for its on-time, then switches off.
// - Alignment blocks receiver laser switch-on; transmitter always toggles.
// - Beam coding option drives the beam coding enable.
// - Applying a configuration drops connection and leaves running state.
module lcsq_top #(
  parameter int unsigned MS_CYC = lcsq_pkg::LCSQ_MS_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_field_clear,
  input wire logic i_aligned,
  input wire logic i_opt_switch,
  input wire logic i_restart,
  input wire logic i_cfg_apply,
  input wire lcsq_pkg::lcsq_cfg_t i_cfg,
  output logic o_status,
  output logic o_conn_up,
  output logic o_rx_laser,
  output logic o_tx_laser,
  output logic o_beam_code
);
  function automatic logic [12:0] sat_inc(input logic [12:0] v);
    sat_inc = (v == lcsq_pkg::LCSQ_MS_MAX) ? v : v + 13'h0001;
  endfunction : sat_inc

  logic ms_tick;
  logic s_tick;
  logic [2:0] pin_m_r;
  logic [2:0] pin_s_r;
  logic sw_q_r;
  lcsq_pkg::lcsq_cfg_t cfg_r;
  lcsq_pkg::lcsq_state_t st_r;
  lcsq_pkg::lcsq_state_t st_nxt;
  logic [12:0] st_cnt_r;
  logic hit_prev_r;
  logic conf_r;
  logic [7:0] dd_cnt_r;
  logic [12:0] clr_cnt_r;
  logic [12:0] lat_cnt_r;
  logic trip_q_r;
  logic [12:0] age1_r;
  logic [12:0] age2_r;
  logic v1_r;
  logic v2_r;
  logic chat_r;
  logic rst_d_r;
  logic [12:0] rst_hi_r;
  logic pu_done_r;
  logic status_nxt;
  logic [7:0] las_cnt_r;
  logic fld_s;
  logic al_s;
  logic sw_s;
  logic run;
  logic obstruct;
  logic trip;
  logic clear_ok;
  logic latch_ok;
  logic ready;
  logic intr;
  logic three;
  logic rst_ev;
  logic sw_ev;

  lcsq_tick #(
    .MS_CYC(MS_CYC),
    .MS_PER_S(lcsq_pkg::LCSQ_S_MS)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .o_ms_tick(ms_tick),
    .o_s_tick(s_tick)
  );

  // Pin synchronisers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      pin_m_r <= 3'h0;
      pin_s_r <= 3'h0;
      sw_q_r <= 1'b0;
    end
    else
    begin
      pin_m_r <= {i_opt_switch, i_aligned, i_field_clear};
      pin_s_r <= pin_m_r;
      sw_q_r <= pin_s_r[2];
    end
  end

  assign fld_s = pin_s_r[0];
  assign al_s = pin_s_r[1];
  assign sw_s = pin_s_r[2];
  assign run = (st_r == lcsq_pkg::LCSQ_RUN);
  assign obstruct = !fld_s;
  assign trip = conf_r && (!cfg_r.dd_en || dd_cnt_r >= cfg_r.dd_ms);
  assign clear_ok = (clr_cnt_r >= cfg_r.on_ms);
  assign latch_ok = (lat_cnt_r >= cfg_r.latch_ms);
  assign ready = run && al_s && !trip && clear_ok && latch_ok && !chat_r;
  assign intr = trip && !trip_q_r;
  assign three = intr && v2_r && (age2_r <= cfg_r.off_ms);
  assign rst_ev = rst_d_r && !i_restart &&
                  (rst_hi_r >= lcsq_pkg::LCSQ_RST_HOLD_MS);
  assign sw_ev = sw_s && !sw_q_r;

  // Operating state and configuration take-over
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      lcsq_pkg::LCSQ_BOOT: st_nxt = lcsq_pkg::LCSQ_RUN;
      lcsq_pkg::LCSQ_RUN:
        if (i_cfg_apply)
          st_nxt = lcsq_pkg::LCSQ_RECONF;
      lcsq_pkg::LCSQ_RECONF:
        if (!i_cfg_apply && st_cnt_r >= lcsq_pkg::LCSQ_RECONF_MS)
          st_nxt = lcsq_pkg::LCSQ_RUN;
      default: st_nxt = lcsq_pkg::LCSQ_BOOT;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      st_r <= lcsq_pkg::LCSQ_BOOT;
      st_cnt_r <= 13'h0000;
      o_conn_up <= 1'b0;
      cfg_r <= lcsq_pkg::LCSQ_CFG_RST;
    end
    else
    begin
      st_r <= st_nxt;
      o_conn_up <= (st_nxt == lcsq_pkg::LCSQ_RUN);
      if (i_cfg_apply)
        cfg_r <= i_cfg;
      if (st_nxt != lcsq_pkg::LCSQ_RECONF || i_cfg_apply)
        st_cnt_r <= 13'h0000;
      else if (ms_tick)
        st_cnt_r <= sat_inc(st_cnt_r);
    end
  end

  // Scan confirmation and demand delay
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || !run)
    begin
      hit_prev_r <= 1'b0;
      conf_r <= 1'b0;
      dd_cnt_r <= 8'h00;
    end
    else
    begin
      if (ms_tick)
      begin
        hit_prev_r <= obstruct;
        conf_r <= obstruct && (!cfg_r.multi_scan || hit_prev_r);
      end
      if (!conf_r)
        dd_cnt_r <= 8'h00;
      else if (ms_tick && dd_cnt_r != 8'hff)
        dd_cnt_r <= dd_cnt_r + 8'h01;
    end
  end

  // Clear time and latch time
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || !run)
    begin
      clr_cnt_r <= 13'h0000;
      lat_cnt_r <= 13'h0000;
    end
    else
    begin
      if (obstruct)
        clr_cnt_r <= 13'h0000;
      else if (ms_tick)
        clr_cnt_r <= sat_inc(clr_cnt_r);
      if (o_status)
        lat_cnt_r <= 13'h0000;
      else if (ms_tick)
        lat_cnt_r <= sat_inc(lat_cnt_r);
    end
  end

  // Interruption history over the sliding window
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || !run)
    begin
      trip_q_r <= 1'b0;
      age1_r <= 13'h0000;
      age2_r <= 13'h0000;
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      chat_r <= 1'b0;
    end
    else
    begin
      trip_q_r <= trip;
      if (intr)
      begin
        age2_r <= age1_r;
        v2_r <= v1_r;
        age1_r <= 13'h0000;
        v1_r <= 1'b1;
      end
      else if (ms_tick)
      begin
        age1_r <= sat_inc(age1_r);
        age2_r <= sat_inc(age2_r);
      end
      if (three)
        chat_r <= 1'b1;
      else if (clear_ok)
        chat_r <= 1'b0;
    end
  end

  // Restart request qualification
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      rst_d_r <= 1'b0;
      rst_hi_r <= 13'h0000;
    end
    else
    begin
      rst_d_r <= i_restart;
      if (!i_restart)
        rst_hi_r <= 13'h0000;
      else if (ms_tick)
        rst_hi_r <= sat_inc(rst_hi_r);
    end
  end

  // Start modes
  always_comb
  begin
    status_nxt = o_status;
    if (!run || trip || !al_s)
      status_nxt = 1'b0;
    else if (!o_status && ready)
    begin
      unique case (cfg_r.mode)
        lcsq_pkg::LCSQ_AUTO: status_nxt = 1'b1;
        lcsq_pkg::LCSQ_PUI: status_nxt = pu_done_r || rst_ev;
        lcsq_pkg::LCSQ_MAN: status_nxt = rst_ev;
        lcsq_pkg::LCSQ_MAN_OFF: status_nxt = rst_ev;
      endcase
    end
    else if (o_status && cfg_r.mode == lcsq_pkg::LCSQ_MAN_OFF && rst_ev)
      status_nxt = 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_status <= 1'b0;
      pu_done_r <= 1'b0;
      o_beam_code <= 1'b0;
    end
    else
    begin
      o_status <= status_nxt;
      o_beam_code <= cfg_r.beam_code;
      if (status_nxt && !o_status)
        pu_done_r <= 1'b1;
    end
  end

  // Alignment lasers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_rx_laser <= 1'b0;
      o_tx_laser <= 1'b0;
      las_cnt_r <= 8'h00;
    end
    else
    begin
      if (sw_ev)
        o_tx_laser <= !o_tx_laser;
      if (sw_ev && o_rx_laser)
        o_rx_laser <= 1'b0;
      else if (sw_ev && !al_s)
      begin
        o_rx_laser <= 1'b1;
        las_cnt_r <= 8'h00;
      end
      else if (o_rx_laser && las_cnt_r >= cfg_r.laser_s)
        o_rx_laser <= 1'b0;
      else if (o_rx_laser && s_tick)
        las_cnt_r <= las_cnt_r + 8'h01;
    end
  end

  sequence s_apply_run;
    run && i_cfg_apply;
  endsequence
  sequence s_dropped;
    !o_conn_up ##1 (!o_conn_up && !o_status);
  endsequence

  property p_reset;
    @(posedge i_clk_sys) !i_nrst |=> !o_status && !o_rx_laser && !chat_r;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_auto;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      cfg_r.mode == lcsq_pkg::LCSQ_AUTO && ready && !o_status |=> o_status;
  endproperty
  a_auto: assert property (p_auto) else $error("auto start missed");

  property p_manual;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(o_status) && $past(cfg_r.mode) == lcsq_pkg::LCSQ_MAN
      |-> $past(rst_ev);
  endproperty
  a_manual: assert property (p_manual) else $error("rise w/o restart");

  property p_toggle;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      cfg_r.mode == lcsq_pkg::LCSQ_MAN_OFF && o_status && rst_ev
      |=> !o_status;
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle off");

  property p_lead;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(i_restart) && !o_status &&
      (cfg_r.mode == lcsq_pkg::LCSQ_MAN ||
       cfg_r.mode == lcsq_pkg::LCSQ_MAN_OFF) |=> !o_status;
  endproperty
  a_lead: assert property (p_lead) else $error("acted on rise");

  property p_trip;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      trip |=> !o_status;
  endproperty
  a_trip: assert property (p_trip) else $error("trip ignored");

  property p_latch;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(o_status) |-> $past(latch_ok) && $past(clear_ok);
  endproperty
  a_latch: assert property (p_latch) else $error("early rise");

  property p_chat;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      three |=> chat_r && !o_status;
  endproperty
  a_chat: assert property (p_chat) else $error("chatter not locked");

  property p_reconf;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      s_apply_run |=> s_dropped;
  endproperty
  a_reconf: assert property (p_reconf) else $error("link kept");

  property p_laser;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      sw_ev && al_s && !o_rx_laser |=> !o_rx_laser;
  endproperty
  a_laser: assert property (p_laser) else $error("rx laser on");
endmodule : lcsq_top
`default_nettype wire

// File: test/lcsq_ctrl_model.sv
// Purpose: Controller side model issuing restart requests
// Assumes: Same clock as the qualifier
// Notes: Request held for a whole number of ms, then released
`timescale 1ns/1ps
`default_nettype none
module lcsq_ctrl_model #(
  parameter int unsigned MS_CYC = 10
) (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic [12:0] i_hold_ms,
  output logic o_restart,
  output logic o_busy
);
  logic req_r = 1'b0;
  logic busy_r = 1'b0;
  int unsigned cnt = 0;
  assign o_restart = req_r;
  assign o_busy = busy_r;
  // Hold high, then release for trailing edge action
  always @(posedge i_clk_sys)
  begin
    if (i_go && !busy_r)
    begin
      busy_r <= 1'b1;
      req_r <= 1'b1;
      cnt <= i_hold_ms * MS_CYC;
    end
    else if (busy_r)
    begin
      if (cnt > 1)
        cnt <= cnt - 1;
      else if (req_r)
        req_r <= 1'b0;
      else
        busy_r <= 1'b0;
    end
  end
endmodule : lcsq_ctrl_model
`default_nettype wire

// File: test/lcsq_top_bench.sv
// Purpose: Self-checking bench for the status qualifier
// Assumes: MS_CYC shortened to 10 cycles
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
module lcsq_top_bench;
  localparam int MS = 10;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic field = 1'b0;
  logic aligned = 1'b0;
  logic sw = 1'b0;
  logic go = 1'b0;
  logic [12:0] hold = 13'h0000;
  logic apply_p = 1'b0;
  logic mscan = 1'b0;
  lcsq_pkg::lcsq_cfg_t cfg = lcsq_pkg::LCSQ_CFG_RST;
  logic restart, busy, status, conn, rx, tx, bc;
  int mismatches = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  lcsq_ctrl_model #(.MS_CYC(MS)) ctrl (.i_clk_sys(clk), .i_go(go),
    .i_hold_ms(hold), .o_restart(restart), .o_busy(busy));
  lcsq_top #(.MS_CYC(MS)) dut (.i_clk_sys(clk), .i_nrst(nrst),
    .i_field_clear(field), .i_aligned(aligned), .i_opt_switch(sw),
    .i_restart(restart), .i_cfg_apply(apply_p), .i_cfg(cfg),
    .o_status(status), .o_conn_up(conn), .o_rx_laser(rx),
    .o_tx_laser(tx), .o_beam_code(bc));
  task report_and_stop;
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task check(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check
  task ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask : ms
  function logic pick(input int sel);
    return sel ? conn : status;
  endfunction : pick
  task wait_out(input int sel, input logic exp, input int bound);
    int i;
    for (i = 0; i < bound * MS && pick(sel) !== exp; i++)
      @(posedge clk);
    check(exp, pick(sel));
    if (pick(sel) !== exp)
      report_and_stop();
  endtask : wait_out
  task do_reset;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    check(1'b0, status);
    check(1'b0, conn);
    check(1'b0, bc);
    check(1'b0, rx);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  task apply(input lcsq_pkg::lcsq_mode_t m, input logic dd,
             input logic [7:0] ddms);
    cfg <= '{mode: m, multi_scan: mscan, dd_en: dd, dd_ms: ddms,
      latch_ms: 13'h0050, on_ms: 13'h001e, off_ms: 13'h001e,
      laser_s: 8'h01, beam_code: 1'b1};
    apply_p <= 1'b1;
    @(posedge clk);
    apply_p <= 1'b0;
    repeat (3) @(posedge clk);
    check(1'b0, conn);
    check(1'b1, bc);
    wait_out(1, 1'b1, 150);
  endtask : apply
  task req(input logic [12:0] n);
    int i;
    go <= 1'b1;
    hold <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 400 * MS && busy; i++)
      @(posedge clk);
    check(1'b0, busy);
    if (busy)
      report_and_stop();
    ms(1);
  endtask : req
  task t_man;
    apply(lcsq_pkg::LCSQ_MAN, 1'b0, 8'h00);
    ms(100);
    check(1'b0, status);
    req(13'h0019);
    check(1'b1, status);
    req(13'h0019);
    check(1'b1, status);
    field <= 1'b0;
    ms(5);
    check(1'b0, status);
    field <= 1'b1;
    ms(100);
    check(1'b0, status);
    req(13'h0019);
    check(1'b1, status);
  endtask : t_man
  task t_chatter;
    apply(lcsq_pkg::LCSQ_AUTO, 1'b0, 8'h00);
    wait_out(0, 1'b1, 150);
    repeat (3)
    begin
      field <= 1'b0;
      ms(2);
      field <= 1'b1;
      ms(3);
    end
    check(1'b0, status);
    ms(20);
    check(1'b0, status);
    wait_out(0, 1'b1, 100);
  endtask : t_chatter
  task t_multi;
    mscan = 1'b1;
    apply(lcsq_pkg::LCSQ_AUTO, 1'b0, 8'h00);
    wait_out(0, 1'b1, 150);
    field <= 1'b0;
    ms(1);
    field <= 1'b1;
    ms(5);
    check(1'b1, status);
    field <= 1'b0;
    ms(5);
    check(1'b0, status);
    field <= 1'b1;
    mscan = 1'b0;
  endtask : t_multi
  task t_auto;
    do_reset();
    field <= 1'b1;
    aligned <= 1'b1;
    ms(400);
    check(1'b0, status);
    wait_out(0, 1'b1, 150);
  endtask : t_auto
  task t_latch;
    apply(lcsq_pkg::LCSQ_AUTO, 1'b0, 8'h00);
    wait_out(0, 1'b1, 150);
    field <= 1'b0;
    ms(5);
    check(1'b0, status);
    field <= 1'b1;
    ms(60);
    check(1'b0, status);
    wait_out(0, 1'b1, 40);
  endtask : t_latch
  task t_delay;
    apply(lcsq_pkg::LCSQ_AUTO, 1'b1, 8'h14);
    wait_out(0, 1'b1, 150);
    field <= 1'b0;
    ms(10);
    field <= 1'b1;
    ms(15);
    check(1'b1, status);
    field <= 1'b0;
    ms(30);
    check(1'b0, status);
    field <= 1'b1;
  endtask : t_delay
  task t_manual;
    apply(lcsq_pkg::LCSQ_MAN_OFF, 1'b0, 8'h00);
    ms(100);
    check(1'b0, status);
    req(13'h0005);
    ms(3);
    check(1'b0, status);
    req(13'h0019);
    check(1'b1, status);
    req(13'h0019);
    check(1'b0, status);
    ms(90);
    req(13'h0019);
    check(1'b1, status);
    field <= 1'b0;
    ms(5);
    field <= 1'b1;
    ms(100);
    check(1'b0, status);
  endtask : t_manual
  task t_interlock;
    do_reset();
    apply(lcsq_pkg::LCSQ_PUI, 1'b0, 8'h00);
    ms(100);
    check(1'b0, status);
    req(13'h0019);
    wait_out(0, 1'b1, 10);
    field <= 1'b0;
    ms(5);
    field <= 1'b1;
    wait_out(0, 1'b1, 150);
  endtask : t_interlock
  task pulse_sw;
    sw <= 1'b1;
    ms(1);
    sw <= 1'b0;
    ms(1);
  endtask : pulse_sw
  task t_laser;
    pulse_sw();
    check(1'b1, tx);
    check(1'b0, rx);
    aligned <= 1'b0;
    pulse_sw();
    check(1'b0, tx);
    check(1'b1, rx);
    ms(2100);
    check(1'b0, rx);
  endtask : t_laser
  initial
  begin
    t_auto();
    t_latch();
    t_delay();
    t_manual();
    t_interlock();
    t_man();
    t_chatter();
    t_multi();
    t_laser();
    report_and_stop();
  end
endmodule : lcsq_top_bench
`default_nettype wire
